// ### rtl/video_dma_map.svh
/*
 * Register offsets, field positions, reset values and sizes of the
 * packet router and video DMA register layer.
 * Assumes inclusion by bare name from the design files under rtl/.
 */
`ifndef VIDEO_DMA_MAP_SVH
`define VIDEO_DMA_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_DMA_FIFO_STATUS 8'h08
`define OFS_DMA_CONTROL 8'h0C
`define OFS_LINK_FIFO_STATUS 8'h14
`define OFS_LINK_FIFO_COMMAND 8'h1C
`define OFS_INTERRUPT_CONTROL 8'h68
`define OFS_DMA_TARGET_ADDRESS 8'h84
`define OFS_DMA_TRANSFER_COUNT 8'h8C
`define OFS_DMA_DESCRIPTOR_POINTER 8'h90
`define OFS_BOARD_IDENTIFICATION 8'hA0
`define OFS_DMA_COMMAND 8'hA8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_FIFO_EMPTY 5
`define BIT_FIFO_FULL 6
`define BIT_FIFO_OVERFLOW 7
`define BIT_CLEAR_DATA_FIFO 1
`define BIT_CLEAR_VIDEO_FIFO 1
`define BIT_UP_LINK_LSB 8
`define BIT_DOWN_LINK_LSB 12
`define BIT_IRQ_FLAG 21
`define BIT_DMA_START 1
`define BIT_DMA_ABORT 2
`define BIT_DMA_CLEAR_IRQ 3
`define COUNT_MSB 21
`define COUNT_LSB 2
`define DESCR_LSB 4
`define ID_TYPE_LSB 0
`define ID_SUBTYPE_LSB 4
`define ID_HW_REV_LSB 8
`define ID_FW_REV_LSB 12
`define ID_FW_SUBREV_LSB 16
`define HDR_TYPE_LSB 0

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define FIFO_DEPTH 16
`define LINK_WIDTH 64
`define BEAT_BYTES 32'h0000_0008

`endif

// ### rtl/video_dma_pkg.sv
/*
 * Types shared by the video DMA register layer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package video_dma_pkg;

    // DMA engine state
    typedef enum logic [0:0] {
        DMA_IDLE = 1'b0,
        DMA_BUSY = 1'b1
    } dma_state_e;

    // Header stripper state
    typedef enum logic [0:0] {
        RX_HEADER = 1'b0,
        RX_BODY = 1'b1
    } strip_state_e;

    typedef logic [7:0] reg_addr_t;
    typedef logic [31:0] reg_word_t;

endpackage

// ### rtl/fifo_buffer.sv
/*
 * Synchronous FIFO in flip-flops with valid and ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps

module fifo_buffer #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Flush
    input wire logic clear,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Levels
    output logic empty,
    output logic full
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] level;
    logic push;
    logic pop;

    // Handshakes and levels
    assign full = (level == (AW+1)'(DEPTH));
    assign empty = (level == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready && !clear;
    assign pop = out_valid && out_ready && !clear;

    // Storage write
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            store[wr_ptr] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else if (clear)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                level <= level + 1'b1;
            end
            else if (pop && !push)
            begin
                level <= level - 1'b1;
            end
        end
    end

endmodule

// ### rtl/video_dma_router.sv
/*
 * Packet router with header stripping, video capture FIFO, data FIFO,
 * 64-bit DMA master front and the register layer behind it.
 * Assumes the link stream, the register port and the DMA master port are
 * all synchronous to ref_clk; the PCI signalling sits outside this block.
 */
`timescale 1ns/1ps
`include "video_dma_map.svh"

// Behaviour
// - A write attempt into a full data FIFO sets the sticky overflow bit 7 of dma_fifo_status.
// - That overflow bit clears only by the clear-data-FIFO action; bits 5 and 6 show data FIFO empty and full.
// - Bit 5 of link_fifo_status reads one while the video FIFO is empty.
// - Bit 6 of link_fifo_status reads one while the video FIFO is full.
// - A video write into a full video FIFO sets the sticky overflow bit 7 of link_fifo_status.
// - Writing one to bit 1 of link_fifo_command empties the video FIFO and clears its overflow bit unless a video write into the full FIFO sets it in that cycle.
// - Bits 8 to 11 of link_fifo_status show upstream channel up, hard, soft and framing error.
// - Bits 12 to 15 of link_fifo_status show the same four downstream link flags.
// - dma_command is write only: bit 1 starts, bit 2 aborts and bit 3 clears the interrupt flag.
// - The identification word holds the board type in bits 3:0 and sub-type in bits 7:4.
// - Bits 11:8 of the identification word hold the fixed hardware revision.
// - Bits 15:12 and 19:16 hold the fixed firmware revision and sub-revision.
// - Exactly one header word is removed from each packet and the rest is forwarded unchanged.
// - Payload of video packets from the downstream link goes into the video FIFO drained by DMA.
// - DMA moves video data as a 64-bit bus master.
module video_dma_router #(
    parameter logic [3:0] BOARD_TYPE = 4'h3, // arbitrary value
    parameter logic [3:0] BOARD_SUBTYPE = 4'h4, // arbitrary value
    parameter logic [3:0] HW_REVISION = 4'h5, // arbitrary value
    parameter logic [3:0] FW_REVISION = 4'h6, // arbitrary value
    parameter logic [3:0] FW_SUBREVISION = 4'h7, // arbitrary value
    parameter logic [7:0] VIDEO_HEADER_CODE = 8'hA5,
    parameter int FIFO_WORDS = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire video_dma_pkg::reg_addr_t reg_addr,
    input wire video_dma_pkg::reg_word_t reg_wdata,
    output video_dma_pkg::reg_word_t reg_rdata,
    // Link health
    input wire logic [3:0] up_link_status,
    input wire logic [3:0] down_link_status,
    // Downstream packet input
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic [`LINK_WIDTH-1:0] rx_data,
    // Forwarded packet output
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_sop,
    output logic tx_eop,
    output logic [`LINK_WIDTH-1:0] tx_data,
    // DMA master write port
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [31:0] dma_addr,
    output logic [`LINK_WIDTH-1:0] dma_data,
    output logic [31:0] dma_descriptor,
    output logic dma_busy
);
    import video_dma_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    strip_state_e strip_state;
    dma_state_e dma_state;
    logic in_video, header_take, body_take, first_body;
    logic data_in_ready, data_empty, data_full, data_overflow;
    logic video_in_ready, video_out_valid, video_empty, video_full, video_overflow, video_write;
    logic [`LINK_WIDTH-1:0] video_out_data;
    logic [`LINK_WIDTH+1:0] data_out_word;
    logic clear_data, clear_video, cmd_start, cmd_abort, cmd_clear_irq;
    logic irq_flag, beat_done, dma_finish;
    logic [31:0] target_address, transfer_count, descriptor_pointer;
    logic [`COUNT_MSB-`COUNT_LSB:0] beats_left;
    reg_word_t next_rdata;

    // Write strobe to a given offset
    function automatic logic hit(input logic wr, input reg_addr_t a, input reg_addr_t ofs);
        hit = wr && (a == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Command strobes
    // ----------------------------------------------------------------
    assign clear_data = hit(reg_wr, reg_addr, `OFS_DMA_CONTROL) && reg_wdata[`BIT_CLEAR_DATA_FIFO];
    assign clear_video = hit(reg_wr, reg_addr, `OFS_LINK_FIFO_COMMAND)
        && reg_wdata[`BIT_CLEAR_VIDEO_FIFO];
    assign cmd_start = hit(reg_wr, reg_addr, `OFS_DMA_COMMAND) && reg_wdata[`BIT_DMA_START];
    assign cmd_abort = hit(reg_wr, reg_addr, `OFS_DMA_COMMAND) && reg_wdata[`BIT_DMA_ABORT];
    assign cmd_clear_irq = hit(reg_wr, reg_addr, `OFS_DMA_COMMAND) && reg_wdata[`BIT_DMA_CLEAR_IRQ];

    // ----------------------------------------------------------------
    // Header stripping and video recognition
    // ----------------------------------------------------------------
    assign header_take = rx_valid && (rx_sop || strip_state == RX_HEADER);
    assign body_take = rx_valid && !header_take;
    assign video_write = body_take && in_video;

    // Packet framing state
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strip_state <= RX_HEADER;
            in_video <= 1'b0;
            first_body <= 1'b0;
        end
        else if (header_take)
        begin
            strip_state <= rx_eop ? RX_HEADER : RX_BODY;
            in_video <= (rx_data[`HDR_TYPE_LSB +: 8] == VIDEO_HEADER_CODE);
            first_body <= 1'b1;
        end
        else if (body_take)
        begin
            strip_state <= rx_eop ? RX_HEADER : RX_BODY;
            first_body <= 1'b0;
        end
    end

    // Forwarding FIFO, payload plus start and end marks
    fifo_buffer #(
        .WIDTH(`LINK_WIDTH + 2),
        .DEPTH(FIFO_WORDS)
    ) data_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(clear_data),
        .in_valid(body_take),
        .in_ready(data_in_ready),
        .in_data({first_body, rx_eop, rx_data}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(data_out_word),
        .empty(data_empty),
        .full(data_full)
    );

    assign tx_sop = data_out_word[`LINK_WIDTH+1];
    assign tx_eop = data_out_word[`LINK_WIDTH];
    assign tx_data = data_out_word[`LINK_WIDTH-1:0];

    // Video capture FIFO drained by the DMA engine
    fifo_buffer #(
        .WIDTH(`LINK_WIDTH),
        .DEPTH(FIFO_WORDS)
    ) video_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(clear_video),
        .in_valid(video_write),
        .in_ready(video_in_ready),
        .in_data(rx_data),
        .out_valid(video_out_valid),
        .out_ready(beat_done),
        .out_data(video_out_data),
        .empty(video_empty),
        .full(video_full)
    );

    // ----------------------------------------------------------------
    // Sticky overflow flags, set wins over clear
    // ----------------------------------------------------------------
    // Data FIFO write while full
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            data_overflow <= 1'b0;
        else if (body_take && !data_in_ready)
            data_overflow <= 1'b1;
        else if (clear_data)
            data_overflow <= 1'b0;
    end

    // Video FIFO write while full
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            video_overflow <= 1'b0;
        else if (video_write && !video_in_ready)
            video_overflow <= 1'b1;
        else if (clear_video)
            video_overflow <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Software-loaded DMA set-up registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            target_address <= `RST_WORD;
            transfer_count <= `RST_WORD;
            descriptor_pointer <= `RST_WORD;
        end
        else
        begin
            if (hit(reg_wr, reg_addr, `OFS_DMA_TARGET_ADDRESS))
                target_address <= reg_wdata;
            if (hit(reg_wr, reg_addr, `OFS_DMA_TRANSFER_COUNT))
                transfer_count <= reg_wdata;
            if (hit(reg_wr, reg_addr, `OFS_DMA_DESCRIPTOR_POINTER))
                descriptor_pointer <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // DMA engine
    // ----------------------------------------------------------------
    assign dma_valid = (dma_state == DMA_BUSY) && video_out_valid;
    assign dma_data = video_out_data;
    assign beat_done = dma_valid && dma_ready;
    assign dma_finish = beat_done && (beats_left == 20'h00001);
    assign dma_busy = (dma_state == DMA_BUSY);

    // Engine state, address walk and beat count
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dma_state <= DMA_IDLE;
            dma_addr <= `RST_WORD;
            dma_descriptor <= `RST_WORD;
            beats_left <= '0;
        end
        else
        begin
            case (dma_state)
                DMA_IDLE:
                begin
                    // start uses what software loaded before it
                    if (cmd_start && !cmd_abort
                        && transfer_count[`COUNT_MSB:`COUNT_LSB] != 20'h00000)
                    begin
                        dma_state <= DMA_BUSY;
                        dma_addr <= target_address;
                        dma_descriptor <= {descriptor_pointer[31:`DESCR_LSB], 4'h0};
                        beats_left <= transfer_count[`COUNT_MSB:`COUNT_LSB];
                    end
                end
                DMA_BUSY:
                begin
                    if (cmd_abort)
                        dma_state <= DMA_IDLE;
                    else if (beat_done)
                    begin
                        dma_addr <= dma_addr + `BEAT_BYTES;
                        beats_left <= beats_left - 20'h00001;
                        if (dma_finish)
                            dma_state <= DMA_IDLE;
                    end
                end
                default: dma_state <= DMA_IDLE;
            endcase
        end
    end

    // Completion flag, set wins over the clear command
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            irq_flag <= 1'b0;
        else if (dma_finish && !cmd_abort)
            irq_flag <= 1'b1;
        else if (cmd_clear_irq)
            irq_flag <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Register read back
    // ----------------------------------------------------------------
    always_comb
    begin
        next_rdata = `RST_WORD;
        case (reg_addr)
            `OFS_DMA_FIFO_STATUS:
            begin
                next_rdata[`BIT_FIFO_EMPTY] = data_empty;
                next_rdata[`BIT_FIFO_FULL] = data_full;
                next_rdata[`BIT_FIFO_OVERFLOW] = data_overflow;
            end
            `OFS_LINK_FIFO_STATUS:
            begin
                next_rdata[`BIT_FIFO_EMPTY] = video_empty;
                next_rdata[`BIT_FIFO_FULL] = video_full;
                next_rdata[`BIT_FIFO_OVERFLOW] = video_overflow;
                next_rdata[`BIT_UP_LINK_LSB +: 4] = up_link_status;
                next_rdata[`BIT_DOWN_LINK_LSB +: 4] = down_link_status;
            end
            `OFS_INTERRUPT_CONTROL: next_rdata[`BIT_IRQ_FLAG] = irq_flag;
            `OFS_DMA_TARGET_ADDRESS: next_rdata = target_address;
            `OFS_DMA_TRANSFER_COUNT: next_rdata[`COUNT_MSB:`COUNT_LSB] = transfer_count[`COUNT_MSB:`COUNT_LSB];
            `OFS_DMA_DESCRIPTOR_POINTER: next_rdata[31:`DESCR_LSB] = descriptor_pointer[31:`DESCR_LSB];
            `OFS_BOARD_IDENTIFICATION:
            begin
                next_rdata[`ID_TYPE_LSB +: 4] = BOARD_TYPE;
                next_rdata[`ID_SUBTYPE_LSB +: 4] = BOARD_SUBTYPE;
                next_rdata[`ID_HW_REV_LSB +: 4] = HW_REVISION;
                next_rdata[`ID_FW_REV_LSB +: 4] = FW_REVISION;
                next_rdata[`ID_FW_SUBREV_LSB +: 4] = FW_SUBREVISION;
            end
            default: next_rdata = `RST_WORD;
        endcase
    end

    // Read data register, loaded on a read strobe
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= `RST_WORD;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence start_taken;
        dma_state == DMA_IDLE && cmd_start && !cmd_abort && transfer_count[`COUNT_MSB:`COUNT_LSB] != 20'h00000;
    endsequence
    sequence last_beat;
        dma_finish && !cmd_abort;
    endsequence

    a_data_ovf_set: assert property (body_take && !data_in_ready |=> data_overflow)
        else $error("data overflow flag not set");
    a_data_ovf_hold: assert property (data_overflow && !clear_data |=> data_overflow)
        else $error("data overflow flag lost");
    a_video_empty_read: assert property (reg_rd && reg_addr == `OFS_LINK_FIFO_STATUS
        |=> reg_rdata[`BIT_FIFO_EMPTY] == $past(video_empty))
        else $error("video empty bit wrong");
    a_video_full_read: assert property (reg_rd && reg_addr == `OFS_LINK_FIFO_STATUS
        |=> reg_rdata[`BIT_FIFO_FULL] == $past(video_full))
        else $error("video full bit wrong");
    a_video_ovf_set: assert property (video_write && video_full |=> video_overflow)
        else $error("video overflow flag not set");
    a_video_clear: assert property (clear_video && !video_write |=> video_empty && !video_overflow)
        else $error("video clear failed");
    a_link_bits_read: assert property (reg_rd && reg_addr == `OFS_LINK_FIFO_STATUS
        |=> reg_rdata[15:8] == {$past(down_link_status), $past(up_link_status)})
        else $error("link health bits wrong");
    a_dma_start_run: assert property (start_taken |=> dma_busy && dma_addr == $past(target_address))
        else $error("start not taken");
    a_dma_abort_stop: assert property (dma_busy && cmd_abort |=> !dma_busy ##1 (!dma_busy || $past(cmd_start)))
        else $error("abort not honoured");
    a_id_word_read: assert property (reg_rd && reg_addr == `OFS_BOARD_IDENTIFICATION
        |=> reg_rdata == {12'h000, FW_SUBREVISION, FW_REVISION, HW_REVISION, BOARD_SUBTYPE, BOARD_TYPE})
        else $error("identification word wrong");
    a_header_dropped: assert property (header_take |-> !video_write ##1 first_body || strip_state == RX_HEADER)
        else $error("header word forwarded");
    a_dma_done_irq: assert property (last_beat |=> irq_flag && !dma_busy)
        else $error("completion flag not set");

endmodule

// ### verification/dma_sink_model.sv
/*
 * Host memory side of the DMA master port: takes beats with random stalls.
 * Assumes ref_clk and active-low nrst shared with the router.
 */
`timescale 1ns/1ps

module dma_sink_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Beat port
    input wire logic dma_valid,
    output logic dma_ready,
    input wire logic [31:0] dma_addr,
    input wire logic [63:0] dma_data,
    // Observation
    output int beats,
    output logic [31:0] last_addr,
    output logic [63:0] last_data
);
    int seed = 27;

    // Accept 64-bit beats, sometimes promptly, sometimes late
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dma_ready <= 1'b0;
            beats <= 0;
            last_addr <= 32'h0;
            last_data <= 64'h0;
        end
        else
        begin
            dma_ready <= $random(seed) % 2 != 0;
            if (dma_valid && dma_ready)
            begin
                beats <= beats + 1;
                last_addr <= dma_addr;
                last_data <= dma_data;
            end
        end
    end
endmodule

// ### verification/video_dma_router_tb_top.sv
/*
 * Self-checking bench for the router register layer, FIFOs and DMA.
 * Assumes dma_sink_model and the rtl files are compiled first.
 */
`timescale 1ns/1ps

module video_dma_router_tb_top;
    import video_dma_pkg::*;
    logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rx_valid = 0, rx_sop = 0, rx_eop = 0, tx_ready = 0;
    reg_addr_t reg_addr = 8'h00;
    reg_word_t reg_wdata = 32'h0, reg_rdata, v;
    logic [3:0] up_link_status = 4'h0, down_link_status = 4'h0;
    logic [63:0] rx_data = 64'h0, tx_data, dma_data, last_data, base;
    logic tx_valid, tx_sop, tx_eop, dma_valid, dma_ready, dma_busy;
    logic [31:0] dma_addr, dma_descriptor, last_addr, ta;
    int beats, num_errors = 0, check_count = 0, seed = 27, k;

    // Clock
    initial forever #10 ref_clk = ~ref_clk;

    video_dma_router video_dma_router_inst (.ref_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .up_link_status, .down_link_status, .rx_valid, .rx_sop, .rx_eop, .rx_data, .tx_valid,
        .tx_ready, .tx_sop, .tx_eop, .tx_data, .dma_valid, .dma_ready, .dma_addr, .dma_data, .dma_descriptor,
        .dma_busy);
    dma_sink_model dma_sink_model_inst (.ref_clk, .nrst, .dma_valid, .dma_ready, .dma_addr, .dma_data,
        .beats, .last_addr, .last_data);

    // Comparison and bus tasks
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input reg_addr_t a, input reg_word_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input reg_addr_t a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic send(input logic [63:0] d, input logic s, input logic e);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data <= d;
        rx_sop <= s;
        rx_eop <= e;
    endtask
    task automatic pkt(input logic [7:0] code, input int n);
        base = {$random(seed), $random(seed)};
        send({56'h0, code}, 1'b1, n == 0);
        for (int i = 0; i < n; i++) send(base + i, 1'b0, i == n - 1);
        @(posedge ref_clk);
        rx_valid <= 1'b0;
    endtask
    function automatic reg_word_t lstat(input logic e, input logic f, input logic o);
        return {16'h0, down_link_status, up_link_status, o, f, e, 5'h0};
    endfunction
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #100000;
        num_errors++;
        summarize;
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        up_link_status <= $random(seed);
        down_link_status <= $random(seed);
        rd(8'h14); chk(v, lstat(1, 0, 0));
        rd(8'hA0); chk(v, 32'h0007_6543);
        rd(8'hA8); chk(v, 32'h0);
        pkt(8'h00, 2);
        rd(8'h08); chk(v, 32'h0);
        chk({tx_valid, tx_sop, tx_eop, tx_data}, {3'b110, base});
        tx_ready <= 1'b1;
        @(posedge ref_clk);
        tx_ready <= 1'b0;
        #1 chk({tx_valid, tx_sop, tx_eop, tx_data}, {3'b101, base + 64'h1});
        wr(8'h0C, 32'h2);
        // Overrun both FIFOs with one long video packet
        pkt(8'hA5, 17);
        rd(8'h08); chk(v, 32'hC0);
        rd(8'h14); chk(v, lstat(0, 1, 1));
        wr(8'h1C, 32'h2);
        rd(8'h14); chk(v, lstat(1, 0, 0));
        rd(8'h08); chk(v, 32'hC0);
        wr(8'h0C, 32'h2);
        rd(8'h08); chk(v, 32'h20);
        // DMA of three video beats with the sink stalling at random
        tx_ready <= 1'b1;
        pkt(8'hA5, 3);
        ta = $random(seed) & 32'hFFFF_FFF8;
        wr(8'h84, ta);
        wr(8'h8C, 32'hC);
        wr(8'h90, 32'h1230);
        wr(8'hA8, 32'h2);
        #1;
        for (k = 0; k < 300 && dma_busy !== 1'b0; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk(dma_busy, 1'b0);
        chk({beats[7:0], last_addr, dma_descriptor}, {8'h3, ta + 32'h10, 32'h1230});
        chk(last_data, base + 64'h2);
        rd(8'h68); chk(v, 32'h0020_0000);
        wr(8'hA8, 32'h8);
        rd(8'h68); chk(v, 32'h0);
        // Abort a started transfer that has no video data to move
        wr(8'h8C, 32'h4);
        wr(8'hA8, 32'h2);
        #1 chk(dma_busy, 1'b1);
        wr(8'hA8, 32'h4);
        #1 chk(dma_busy, 1'b0);
        rd(8'h68); chk(v, 32'h0);
        summarize;
    end
endmodule
